// File: verilog/tws_slave.v
`timescale 1ns/1ns
`include "tws_map.vh"

module tws_slave #(
    parameter TIMEOUT_CYCLES = `TWS_TIMEOUT_CYCLES
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire address_select_pin_i,
    output reg sda_o,
    output reg sda_oe_o,
    output reg [15:0] config_o,
    output reg enabled_o,
    output reg hs_mode_o
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RX = 5'h02;
    localparam [4:0] S_ACK = 5'h04;
    localparam [4:0] S_TX = 5'h08;
    localparam [4:0] S_MACK = 5'h10;
    localparam [31:0] TIMEOUT_FULL = TIMEOUT_CYCLES;
    // counter fits the default limit, upper bits dropped on purpose
    localparam [`TWS_TIMER_W-1:0] TIMEOUT_LIM = TIMEOUT_FULL[`TWS_TIMER_W-1:0];

    wire scl_f;
    wire sda_f;
    wire pin_f;
    reg scl_d;
    reg sda_d;
    reg [4:0] state;
    reg [3:0] bit_cnt;
    reg [1:0] byte_cnt;
    reg [7:0] rx_shift;
    reg [7:0] tx_shift;
    reg [7:0] msb_hold;
    reg is_gc;
    reg is_read;
    reg master_ack;
    reg not_sda;
    reg not_scl;
    reg pin_high;
    reg [`TWS_TIMER_W-1:0] timer;

    // ==========================================================
    // input conditioning
    // one synchroniser per pin: clock, data, address select
    wire [2:0] raw_in = {address_select_pin_i, sda_i, scl_i};
    wire [2:0] sync_out;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            tws_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .d_i(raw_in[gi]),
                .q_o(sync_out[gi])
            );
        end
    endgenerate
    assign scl_f = sync_out[0];
    assign sda_f = sync_out[1];
    assign pin_f = sync_out[2];

    wire scl_rise = scl_f & ~scl_d;
    wire scl_fall = ~scl_f & scl_d;
    wire start_det = scl_f & scl_d & sda_d & ~sda_f;
    wire stop_det = scl_f & scl_d & ~sda_d & sda_f;

    // ==========================================================
    // own address from how the select pin behaves
    function [6:0] own_addr;
        input ns;
        input nc;
        input ph;
        begin
            if (!nc) begin
                own_addr = `TWS_ADDR_BASE | 7'h03;
            end else if (!ns) begin
                own_addr = `TWS_ADDR_BASE | 7'h02;
            end else if (ph) begin
                own_addr = `TWS_ADDR_BASE | 7'h01;
            end else begin
                own_addr = `TWS_ADDR_BASE;
            end
        end
    endfunction

    wire [6:0] my_addr = own_addr(not_sda, not_scl, pin_high);

    // ==========================================================
    // protocol engine
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            byte_cnt <= 2'h0;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            msb_hold <= 8'h00;
            is_gc <= 1'b0;
            is_read <= 1'b0;
            master_ack <= 1'b0;
            not_sda <= 1'b0;
            not_scl <= 1'b0;
            pin_high <= 1'b0;
            timer <= {`TWS_TIMER_W{1'b0}};
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            config_o <= `TWS_CFG_DEFAULT;
            enabled_o <= 1'b1;
            hs_mode_o <= 1'b0;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
            enabled_o <= config_o[`TWS_CFG_EN_BIT];
            // a low clock that never returns would hang the bus
            if (state == S_IDLE || scl_rise || scl_fall) begin
                timer <= {`TWS_TIMER_W{1'b0}};
            end else begin
                timer <= timer + 1'b1;
            end
            if (stop_det) begin
                state <= S_IDLE;
                sda_oe_o <= 1'b0;
                hs_mode_o <= 1'b0;
            end else if (start_det) begin
                state <= S_RX;
                sda_oe_o <= 1'b0;
                bit_cnt <= 4'h0;
                byte_cnt <= 2'h0;
                is_gc <= 1'b0;
                // a stale read flag would turn a general call into a read
                is_read <= 1'b0;
                not_sda <= 1'b0;
                not_scl <= 1'b0;
                pin_high <= pin_f;
            end else if (timer >= TIMEOUT_LIM) begin
                state <= S_IDLE;
                sda_oe_o <= 1'b0;
                hs_mode_o <= 1'b0;
            end else begin
                if (state == S_RX && byte_cnt == 2'h0) begin
                    not_sda <= not_sda | (pin_f != sda_f);
                    not_scl <= not_scl | (pin_f != scl_f);
                end
                case (state)
                    S_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    S_RX: begin
                        if (scl_rise && bit_cnt != 4'h8) begin
                            rx_shift <= {rx_shift[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            state <= S_IDLE;
                            if (byte_cnt == 2'h0) begin
                                if (rx_shift[7:1] == `TWS_GC_ADDR && !rx_shift[0]) begin
                                    is_gc <= 1'b1;
                                    sda_oe_o <= 1'b1;
                                    state <= S_ACK;
                                end else if (rx_shift[7:1] == my_addr) begin
                                    is_read <= rx_shift[0];
                                    sda_oe_o <= 1'b1;
                                    state <= S_ACK;
                                end else if (rx_shift[7:3] == `TWS_HS_CODE_TOP) begin
                                    hs_mode_o <= 1'b1;
                                end
                            end else if (is_gc) begin
                                if (byte_cnt == 2'h1) begin
                                    sda_oe_o <= 1'b1;
                                    state <= S_ACK;
                                    case (rx_shift)
                                        `TWS_GC_RESET: config_o <= `TWS_CFG_DEFAULT;
                                        `TWS_GC_ENABLE: config_o[`TWS_CFG_EN_BIT] <= 1'b1;
                                        `TWS_GC_DISABLE: config_o[`TWS_CFG_EN_BIT] <= 1'b0;
                                        default: config_o <= config_o;
                                    endcase
                                end
                            end else begin
                                sda_oe_o <= 1'b1;
                                state <= S_ACK;
                                if (byte_cnt == 2'h1) begin
                                    msb_hold <= rx_shift;
                                end else if (byte_cnt == 2'h2) begin
                                    config_o <= {msb_hold, rx_shift};
                                end
                            end
                            if (byte_cnt != 2'h3) begin
                                byte_cnt <= byte_cnt + 2'h1;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                tx_shift <= config_o[15:8];
                                sda_oe_o <= ~config_o[15];
                                bit_cnt <= 4'h0;
                                byte_cnt <= 2'h1;
                                state <= S_TX;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h7) begin
                                sda_oe_o <= 1'b0;
                                state <= S_MACK;
                            end else begin
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                sda_oe_o <= ~tx_shift[6];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_f;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (master_ack) begin
                                // upper and lower bytes alternate for long reads
                                byte_cnt <= byte_cnt ^ 2'h1;
                                if (byte_cnt == 2'h1) begin
                                    tx_shift <= config_o[7:0];
                                    sda_oe_o <= ~config_o[7];
                                end else begin
                                    tx_shift <= config_o[15:8];
                                    sda_oe_o <= ~config_o[15];
                                end
                                state <= S_TX;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // tws_slave

// File: verilog/tws_map.vh
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ==========================================================
// bus codes
`define TWS_GC_ADDR 7'h00
`define TWS_GC_RESET 8'h06
`define TWS_GC_ENABLE 8'h81
`define TWS_GC_DISABLE 8'h82
`define TWS_ADDR_BASE 7'h40
`define TWS_HS_CODE_TOP 5'h01

// ==========================================================
// configuration register
`define TWS_CFG_DEFAULT 16'h8000
`define TWS_CFG_EN_BIT 15

// ==========================================================
// timing
`define TWS_CLK_HZ 20000000
`define TWS_TIMEOUT_MS 28
`define TWS_TIMEOUT_CYCLES ((`TWS_TIMEOUT_MS * `TWS_CLK_HZ) / 1000)
`define TWS_TIMER_W 20

`endif

// File: verilog/tws_sync.v
`timescale 1ns/1ns

// ==========================================================
// three-stage synchroniser, change taken once stages two and three agree
module tws_sync (
    input wire clk_sys_i,
    input wire rst_i,
    input wire d_i,
    output reg q_o
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            q_o <= 1'b1;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s3;
            end
        end
    end
endmodule // tws_sync

// File: tb/tws_slave_chk.sv
`timescale 1ns/1ns
`include "tws_map.vh"
// ==========================================================
// port checker
module tws_slave_chk #(
    parameter int TIMEOUT_CYCLES = 2000
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire address_select_pin_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire [15:0] config_o,
    input wire enabled_o,
    input wire hs_mode_o
);
    int idle_cnt;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // capped so a parked bus cannot wrap it
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) idle_cnt <= 0;
        else if ($changed(scl_i)) idle_cnt <= 0;
        else if (idle_cnt < TIMEOUT_CYCLES + 64) idle_cnt <= idle_cnt + 1;
    end
    // three samples high first, so a late release after a clock fall is not taken for a stop
    sequence s_stop;
        scl_i && $past(scl_i) && $past(scl_i, 2) && $rose(sda_i);
    endsequence
    sequence s_quiet;
        !sda_oe_o [*8];
    endsequence
    AST_RESET_VALS: assert property ($fell(rst_i) |-> config_o == `TWS_CFG_DEFAULT && enabled_o && !hs_mode_o)
        else $error("reset values wrong");
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    AST_EN_COPY: assert property (enabled_o == $past(config_o[15]))
        else $error("enable state not tracking bit 15");
    AST_CFG_ACKED: assert property ($changed(config_o) |-> ##[0:8] sda_oe_o)
        else $error("config changed outside an acknowledge");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 4))
        else $error("data changed while clock high");
    AST_HS_NO_ACK: assert property ($rose(hs_mode_o) |-> s_quiet)
        else $error("high-speed code acknowledged");
    AST_HS_STOP: assert property (s_stop |-> ##[1:10] !hs_mode_o)
        else $error("stop left high-speed mode on");
    AST_TIMEOUT: assert property (sda_oe_o |-> idle_cnt < TIMEOUT_CYCLES + 16)
        else $error("bus held past timeout");
endmodule // tws_slave_chk

bind tws_slave tws_slave_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .scl_i(scl_i), .sda_i(sda_i), .address_select_pin_i(address_select_pin_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .config_o(config_o), .enabled_o(enabled_o), .hs_mode_o(hs_mode_o));

// File: tb/tws_bus_master.sv
`timescale 1ns/1ns
// ==========================================================
// bit-level bus master, data line pulled up when released
module tws_bus_master (
    input wire sda_i,
    output logic scl_o = 1'b1,
    output logic sda_low_o = 1'b0
);
    // slave needs half periods of eight clocks, so 200 ns quarters
    int quarter = 200;
    task automatic bit_io(input logic b, output logic r);
        #(quarter) sda_low_o = !b;
        #(quarter) scl_o = 1'b1;
        #(2 * quarter) r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic start;
        #(quarter) sda_low_o = 1'b0;
        #(quarter) scl_o = 1'b1;
        #(quarter) sda_low_o = 1'b1;
        #(quarter) scl_o = 1'b0;
    endtask
    task automatic stop;
        #(quarter) sda_low_o = 1'b1;
        #(quarter) scl_o = 1'b1;
        #(quarter) sda_low_o = 1'b0;
        // idle long enough for the slave to see the stop
        #(2 * quarter);
    endtask
    // eight data bits then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(nine, ack);
    endtask
endmodule // tws_bus_master

// File: tb/tb_two_wire_slave_general_call.sv
`timescale 1ns/1ns
`include "tws_map.vh"
// ==========================================================
// bench
module tb_two_wire_slave_general_call;
    localparam int TMO = 2000;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] pin_mode = 2'h0;
    logic scl, sda_low, sda_o, sda_oe_o, enabled_o, hs_mode_o, ak;
    logic [15:0] config_o, model_cfg, v;
    logic [7:0] rx;
    logic [7:0] gc_code [$] = '{8'h82, 8'h81, 8'h5a, 8'h06, 8'h81};
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    wire sda = !(sda_low || (sda_oe_o && !sda_o));
    wire address_select_pin_i = pin_mode[1] ? (pin_mode[0] ? scl : sda) : pin_mode[0];
    tws_slave #(.TIMEOUT_CYCLES(TMO)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .address_select_pin_i(address_select_pin_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .config_o(config_o),
        .enabled_o(enabled_o), .hs_mode_o(hs_mode_o));
    tws_bus_master u_mst (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic finish_test;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask
    // header then nb data bytes, upper byte first, no stop
    task automatic wr_frame(input logic [7:0] hdr, input logic [15:0] d, input int nb, input logic ok);
        u_mst.start();
        u_mst.xfer(hdr, 1'b1, rx, ak);
        chk1(ak, !ok);
        for (int i = 0; i < nb; i++) begin
            u_mst.xfer(i == 0 ? d[15:8] : d[7:0], 1'b1, rx, ak);
            chk1(ak, !ok);
        end
    endtask
    task automatic rd_frame(input logic [15:0] exp);
        u_mst.start();
        u_mst.xfer(8'h81, 1'b1, rx, ak);
        chk1(ak, 1'b0);
        u_mst.xfer(8'hff, 1'b0, rx, ak);
        chk({8'h0, rx}, {8'h0, exp[15:8]});
        u_mst.xfer(8'hff, 1'b0, rx, ak);
        chk({8'h0, rx}, {8'h0, exp[7:0]});
        // a third byte starts the word over again
        u_mst.xfer(8'hff, 1'b1, rx, ak);
        chk({8'h0, rx}, {8'h0, exp[15:8]});
        u_mst.stop();
    endtask
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            n_errors++;
            $display("[ERR] %0t run did not finish", $time);
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'h5be4));
        repeat (16) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        model_cfg = `TWS_CFG_DEFAULT;
        chk(config_o, model_cfg);
        chk1(hs_mode_o, 1'b0);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            v = 16'($urandom());
            v[15] = k[0];
            wr_frame(8'h80, v, 2, 1'b1);
            u_mst.stop();
            model_cfg = v;
            chk(config_o, model_cfg);
            chk1(enabled_o, model_cfg[15]);
            rd_frame(model_cfg);
            // a lone byte must not reach the register
            wr_frame(8'h80, ~v, 1, 1'b1);
            u_mst.stop();
            chk(config_o, model_cfg);
        end
        $display("write read test done");
        for (int k = 0; k < 5; k++) begin
            wr_frame(8'h00, {gc_code[k], 8'h00}, 1, 1'b1);
            u_mst.stop();
            case (gc_code[k])
                `TWS_GC_RESET: model_cfg = `TWS_CFG_DEFAULT;
                `TWS_GC_ENABLE: model_cfg[15] = 1'b1;
                `TWS_GC_DISABLE: model_cfg[15] = 1'b0;
                default: model_cfg = model_cfg;
            endcase
            chk(config_o, model_cfg);
            chk1(enabled_o, model_cfg[15]);
        end
        wr_frame(8'h01, 16'h0, 0, 1'b0);
        u_mst.stop();
        $display("general call test done");
        wr_frame(8'h84, 16'h0, 0, 1'b0);
        u_mst.stop();
        // pin at supply, then tied to the data wire, then to the clock wire
        for (int m = 1; m < 4; m++) begin
            pin_mode = 2'(m);
            v = 16'($urandom());
            wr_frame({5'h10, 2'(m), 1'b0}, v, 2, 1'b1);
            u_mst.stop();
            model_cfg = v;
            chk(config_o, model_cfg);
        end
        pin_mode = 2'h0;
        $display("address test done");
        // master code at no more than 400 kHz
        u_mst.quarter = 650;
        u_mst.start();
        u_mst.xfer(8'h0b, 1'b1, rx, ak);
        u_mst.quarter = 200;
        chk1(ak, 1'b1);
        chk1(hs_mode_o, 1'b1);
        v = 16'($urandom());
        wr_frame(8'h80, v, 2, 1'b1);
        chk1(hs_mode_o, 1'b1);
        u_mst.stop();
        model_cfg = v;
        chk1(hs_mode_o, 1'b0);
        rd_frame(model_cfg);
        $display("high speed test done");
        u_mst.quarter = 650;
        u_mst.start();
        u_mst.xfer(8'h0f, 1'b1, rx, ak);
        u_mst.quarter = 200;
        u_mst.start();
        for (int i = 7; i >= 0; i--) u_mst.bit_io(i == 7, ak);
        repeat (10) @(posedge clk_sys_i);
        #1 chk1(sda_oe_o, 1'b1);
        repeat (TMO + 100) @(posedge clk_sys_i);
        #1 chk1(sda_oe_o, 1'b0);
        chk1(hs_mode_o, 1'b0);
        u_mst.stop();
        chk(config_o, model_cfg);
        $display("timeout test done");
        finish_test();
    end
endmodule // tb_two_wire_slave_general_call
